// *** shared/adc_readout_pkg.sv ***
// shared constants and carrier types for the conversion result readout port
// assumes the converter core and the port share one clock and one reset
`default_nettype none
package adc_readout_pkg;

  // result bank shape
  localparam int CHANNELS = 8;
  localparam int WORD_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int PTR_BITS = 3;
  localparam int BYTE_PTR_BITS = 4;
  localparam int SER_BITS = 7;

  // serial slot numbers and the group offset that swaps channels 1-4 with 5-8
  localparam logic [PTR_BITS-1:0] SLOT_FIRST = 3'h0;
  localparam logic [PTR_BITS-1:0] GROUP_SWAP = 3'h4;

  // byte mode: the first two strobes belong to channel 1
  localparam logic [BYTE_PTR_BITS-1:0] BYTE_FIRST_LAST = 4'h1;

  // reset values and bus enable patterns
  localparam logic [WORD_BITS-1:0] WORD_ZERO = 16'h0000;
  localparam logic [WORD_BITS-1:0] OE_NONE = 16'h0000;
  localparam logic [WORD_BITS-1:0] OE_ALL = 16'hffff;
  localparam logic [WORD_BITS-1:0] OE_LOW_BYTE = 16'h00ff;

  // readout interface chosen by the two select pins
  typedef enum logic [1:0] {
    MODE_PARALLEL = 2'b00,
    MODE_BYTE = 2'b01,
    MODE_SERIAL = 2'b10
  } mode_type;

  // all eight stored results, channel 1 at index 0
  typedef logic [CHANNELS-1:0][WORD_BITS-1:0] resultBank_type;

  // static select pins, sampled as one group
  typedef struct packed {
    logic interfaceSelect;
    logic byteModeSelect;
    logic highByteFirst;
  } modePins_type;

  // read strobes from the host, both active low
  typedef struct packed {
    logic csN;
    logic rdN;
  } strobes_type;

endpackage : adc_readout_pkg
`default_nettype wire

// *** src/adc_result_readout_port.sv ***
// conversion result readout port: stores eight results at the end of a
// conversion and hands them to a host over parallel, byte or serial pins.
// assumes coreBusy and coreResults come from the converter core on clk, the
// host pins are asynchronous to clk, and sclk idles high between frames.
// timing notes for whoever drives the pins
// - host pins pass two clk flip-flops, so a strobe edge is seen one to two clk late
// - read strobes must stay low and stay high for at least three clk each,
//   otherwise an edge can slip between two samples and a word is skipped
// - parallel and byte data are registered one clk after the edge is seen
// - enables follow the synchronised chip select and lag the pin by two clk
// - serial lines come from the sclk counters and the bank with no clk stage,
//   so the top bit is ready as soon as the enables turn on
// - the first sclk edge of a frame must come well after chip select falls,
//   because the counter restart is released by clk logic
// - the bank is written whenever busy falls, whatever chip select does; a host that reads
//   across busy falling may see a word torn between two samples
// - byte mode leaves the upper eight data lines undriven; they are inputs there
// - the parallel pointer wraps after eight words, the byte pointer after sixteen
// - serial counters wrap after 128 clocks, one full pass of line A
`default_nettype none
module adc_result_readout_port
  import adc_readout_pkg::*;
(
  // system clock and reset
  input wire logic clk,
  input wire logic rstn,
  // serial clock from the host
  input wire logic sclk,
  // converter core
  input wire logic coreBusy,
  input wire resultBank_type coreResults,
  output logic busy,
  // select pins
  input wire modePins_type modePins,
  // read strobes
  input wire strobes_type strobes,
  // parallel and byte bus
  output logic [WORD_BITS-1:0] parallelDataOut,
  output logic [WORD_BITS-1:0] parallelDataOe,
  // serial lines
  output logic serialOutA,
  output logic serialOutAOe,
  output logic serialOutB,
  output logic serialOutBOe,
  // first-channel flag
  output logic firstChannelFlag,
  output logic firstChannelFlagOe
);

  // state on clk
  typedef struct packed {
    logic csSync1;
    logic csSync2;
    logic rdSync1;
    logic rdSync2;
    logic rdPrev;
    modePins_type modeSync1;
    modePins_type modeSync2;
    logic coreBusyPrev;
    logic busy;
    resultBank_type bank;
    logic [BYTE_PTR_BITS-1:0] readPtr;
    logic [WORD_BITS-1:0] dataOut;
    logic flagPar;
    logic restartPending;
    logic restartLink;
  } mainState_type;

  // serial state moved on rising sclk
  typedef struct packed {
    logic [SER_BITS-1:0] riseCount;
  } riseState_type;

  // serial state moved on falling sclk
  typedef struct packed {
    logic [SER_BITS-1:0] fallCount;
  } fallState_type;

  mainState_type state;
  mainState_type next_state;
  riseState_type riseState;
  riseState_type next_riseState;
  fallState_type fallState;
  fallState_type next_fallState;
  mode_type mode;
  logic readEdge;
  logic bankUpdate;
  logic linkRstN;
  logic [PTR_BITS-1:0] slotA;
  logic [PTR_BITS-1:0] slotB;
  logic [BYTE_PTR_BITS-1:0] bitIdx;
  logic flagSer;
  logic [WORD_BITS-1:0] pickedWord;
  logic [BYTE_BITS-1:0] pickedByte;
  // decoded mode and selection, shared by the strobe logic
  logic parallelMode;
  logic byteMode;
  logic selected;

  // decode of the two select pins, byte select ignored when interface select is low
  function automatic mode_type decodeMode(input modePins_type pins);
    if (!pins.interfaceSelect) begin
      decodeMode = MODE_PARALLEL;
    end else if (pins.byteModeSelect) begin
      decodeMode = MODE_BYTE;
    end else begin
      decodeMode = MODE_SERIAL;
    end
  endfunction : decodeMode

  // byte of a result for a given strobe index and byte order
  function automatic logic [BYTE_BITS-1:0] pickByte(input logic [WORD_BITS-1:0] word,
                                                   input logic secondByte,
                                                   input logic highFirst);
    if (secondByte ^ highFirst) begin
      pickByte = word[WORD_BITS-1:BYTE_BITS];
    end else begin
      pickByte = word[BYTE_BITS-1:0];
    end
  endfunction : pickByte

  // derived terms on clk, from synchronised pins and the raw core busy
  always_comb begin
    mode = decodeMode(state.modeSync2);
    parallelMode = (mode == MODE_PARALLEL);
    byteMode = (mode == MODE_BYTE);
    // chip select low enables the port; strobes are ignored otherwise
    selected = !state.csSync2;
    readEdge = state.rdPrev && !state.rdSync2 && selected;
    bankUpdate = state.coreBusyPrev && !coreBusy;
    pickedWord = state.bank[state.readPtr[PTR_BITS-1:0]];
    pickedByte = pickByte(state.bank[state.readPtr[BYTE_PTR_BITS-1:1]], state.readPtr[0],
                          state.modeSync2.highByteFirst);
  end

  // next state on clk
  always_comb begin
    next_state = state;
    // two flip-flops for every host pin before use on clk
    next_state.csSync1 = strobes.csN;
    next_state.csSync2 = state.csSync1;
    next_state.rdSync1 = strobes.rdN;
    next_state.rdSync2 = state.rdSync1;
    next_state.rdPrev = state.rdSync2;
    next_state.modeSync1 = modePins;
    next_state.modeSync2 = state.modeSync1;
    // busy follows the core, so the bank changes in the cycle busy falls
    next_state.coreBusyPrev = coreBusy;
    next_state.busy = coreBusy;
    if (bankUpdate) begin
      next_state.bank = coreResults;
      next_state.readPtr = '0;
    end else if (readEdge && parallelMode) begin
      // each read edge outside a bank update cycle latches the pointed word and steps on, wrapping after 8
      next_state.dataOut = pickedWord;
      next_state.flagPar = (state.readPtr[PTR_BITS-1:0] == SLOT_FIRST);
      next_state.readPtr = {1'b0, state.readPtr[PTR_BITS-1:0] + 3'h1};
    end else if (readEdge && byteMode) begin
      // low lines carry the byte, upper lines are inputs in this mode
      next_state.dataOut = {{BYTE_BITS{1'b0}}, pickedByte};
      next_state.flagPar = (state.readPtr <= BYTE_FIRST_LAST);
      next_state.readPtr = state.readPtr + 4'h1;
    end
    // restart the serial counters while chip select is high after an update;
    // the host keeps chip select high across the update, so no frame is cut
    if (bankUpdate) begin
      next_state.restartPending = 1'b1;
    end else if (state.restartLink && !state.csSync2) begin
      next_state.restartPending = 1'b0;
    end
    next_state.restartLink = state.restartPending && state.csSync2;
  end

  // clk registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= '{
        csSync1: 1'b1,
        csSync2: 1'b1,
        rdSync1: 1'b1,
        rdSync2: 1'b1,
        rdPrev: 1'b1,
        modeSync1: '0,
        modeSync2: '0,
        coreBusyPrev: 1'b0,
        busy: 1'b0,
        bank: '0,
        readPtr: '0,
        dataOut: WORD_ZERO,
        flagPar: 1'b0,
        restartPending: 1'b0,
        restartLink: 1'b0
      };
    end else begin
      state <= next_state;
    end
  end

  // serial domain reset: the restart level from clk clears the counters to a constant;
  // it drops a few clk cycles after chip select falls, long before the first sclk edge
  assign linkRstN = rstn && !state.restartLink;

  // rising sclk shifts the next bit out, only inside a frame
  always_comb begin
    next_riseState = riseState;
    if (!strobes.csN) begin
      next_riseState.riseCount = riseState.riseCount + 7'h01;
    end
  end

  // falling sclk counts sampled bits for the flag
  always_comb begin
    next_fallState = fallState;
    if (!strobes.csN) begin
      next_fallState.fallCount = fallState.fallCount + 7'h01;
    end
  end

  // sclk registers; chip select is driven by the host in step with sclk
  always_ff @(posedge sclk or negedge linkRstN) begin
    if (!linkRstN) begin
      riseState <= '{riseCount: '0};
    end else begin
      riseState <= next_riseState;
    end
  end

  always_ff @(negedge sclk or negedge linkRstN) begin
    if (!linkRstN) begin
      fallState <= '{fallCount: '0};
    end else begin
      fallState <= next_fallState;
    end
  end

  // serial bit selection; the bank is steady during frames, so it is read directly
  always_comb begin
    slotA = riseState.riseCount[SER_BITS-1:BYTE_PTR_BITS];
    slotB = slotA ^ GROUP_SWAP;
    bitIdx = ~riseState.riseCount[BYTE_PTR_BITS-1:0]; // top bit first
    // flag marks channel 1 on line A and channel 5 on line B in the same slot
    flagSer = (fallState.fallCount[SER_BITS-1:BYTE_PTR_BITS] == SLOT_FIRST);
  end

  // one bit per serial line; both lines share the bit index, only the slot differs,
  // so line B runs a half pass ahead of line A through the bank
  logic [1:0] serialBit;
  genvar lineIdx;
  generate
    for (lineIdx = 0; lineIdx < 2; lineIdx++) begin : g_line
      logic [PTR_BITS-1:0] lineSlot;
      // line 0 is A, line 1 is B with the group swapped
      assign lineSlot = (lineIdx == 0) ? slotA : slotB;
      assign serialBit[lineIdx] = state.bank[lineSlot][bitIdx];
    end
  endgenerate

  // pin drivers; enables follow the synchronised chip select.
  // only the enables and the flag source depend on the mode, so a mode change while selected
  // switches line ownership at once; the host must keep the select pins static
  // while chip select is low, or the bus may briefly fight an external driver
  always_comb begin
    busy = state.busy;
    parallelDataOut = state.dataOut;
    serialOutA = serialBit[0];
    serialOutB = serialBit[1];
    parallelDataOe = OE_NONE;
    serialOutAOe = 1'b0;
    serialOutBOe = 1'b0;
    firstChannelFlag = 1'b0;
    firstChannelFlagOe = 1'b0;
    case (mode)
      MODE_PARALLEL: begin
        parallelDataOe = state.csSync2 ? OE_NONE : OE_ALL;
        firstChannelFlag = state.flagPar;
        firstChannelFlagOe = !state.csSync2;
      end
      MODE_BYTE: begin
        parallelDataOe = state.csSync2 ? OE_NONE : OE_LOW_BYTE;
        firstChannelFlag = state.flagPar;
        firstChannelFlagOe = !state.csSync2;
      end
      MODE_SERIAL: begin
        serialOutAOe = !state.csSync2;
        serialOutBOe = !state.csSync2;
        firstChannelFlag = flagSer;
        firstChannelFlagOe = !state.csSync2;
      end
      default: begin
        parallelDataOe = OE_NONE;
      end
    endcase
  end

endmodule : adc_result_readout_port
`default_nettype wire

// *** tb/adc_result_readout_port_asserts.sv ***
// checker for the readout port: pin enables, busy copy, hold of output data
// assumes the bind below reaches every instance of the port
`default_nettype none
module adc_result_readout_port_asserts
  import adc_readout_pkg::*;
(
  // clocks and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic sclk,
  // inputs seen
  input wire logic coreBusy,
  input wire modePins_type modePins,
  input wire strobes_type strobes,
  // outputs checked
  input wire logic busy,
  input wire logic [WORD_BITS-1:0] parallelDataOut,
  input wire logic [WORD_BITS-1:0] parallelDataOe,
  input wire logic serialOutA,
  input wire logic serialOutAOe,
  input wire logic firstChannelFlagOe
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // pins pass a two-stage sync, so enables are judged after five steady samples
  a_par_drive: assert property ((!modePins[2] && !strobes.csN)[*5]
    |-> parallelDataOe == OE_ALL) else $error("parallel bus not driven");
  a_byte_drive: assert property ((modePins[2:1] == 2'b11 && !strobes.csN)[*5]
    |-> parallelDataOe == OE_LOW_BYTE) else $error("byte bus not driven");
  a_ser_drive: assert property ((modePins[2:1] == 2'b10 && !strobes.csN)[*5]
    |-> serialOutAOe && parallelDataOe == OE_NONE) else $error("serial line not driven");
  a_idle_float: assert property (strobes.csN[*5]
    |-> !serialOutAOe && !firstChannelFlagOe && parallelDataOe == OE_NONE)
    else $error("outputs driven while deselected");
  a_flag_drive: assert property ((!strobes.csN)[*5] |-> firstChannelFlagOe)
    else $error("flag not driven");
  // busy is the core busy one clock late
  a_busy_follow: assert property (coreBusy[*2] |-> busy) else $error("busy missing");
  // outputs move only on a read edge, a serial clock edge or a result update
  a_par_hold: assert property ((strobes.rdN && $stable(coreBusy))[*6]
    |-> $stable(parallelDataOut)) else $error("parallel data moved without a read");
  a_ser_hold: assert property ((!strobes.csN && $stable(sclk))[*4]
    |-> $stable(serialOutA)) else $error("serial data moved without a clock");
endmodule : adc_result_readout_port_asserts
bind adc_result_readout_port adc_result_readout_port_asserts checks (.*);
`default_nettype wire

// *** tb/host_serial_model.sv ***
// host model for serial mode: frames, serial clock and bit capture
// assumes z on any line that the port does not drive
`default_nettype none
module host_serial_model (
  // to the port
  output logic sclk,
  output logic csN,
  // from the port
  input wire logic lineA,
  input wire logic lineB,
  input wire logic flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] capA [8];
  logic [15:0] capB [8];
  logic flagSeen [8];
  // serial clock idles high and runs only inside a frame
  initial {sclk, csN} = 2'b11;
  // bits taken at the falling edge, flag halfway through the first bit
  task automatic frame(input int words, input int base);
    csN = 1'b0;
    #40;
    for (int n = 0; n < 16 * words; n++) begin
      sclk = 1'b0;
      capA[base+n/16] = {capA[base+n/16][14:0], lineA};
      capB[base+n/16] = {capB[base+n/16][14:0], lineB};
      #80;
      if (n % 16 == 0) flagSeen[base+n/16] = flag;
      sclk = 1'b1;
      #80;
    end
    csN = 1'b1;
    #100;
  endtask : frame
endmodule : host_serial_model
`default_nettype wire

// *** tb/adc_result_readout_port_test.sv ***
// bench for the readout port: parallel, byte and serial reads of random results
// assumes the host model owns the serial clock; the bench owns the other pins
`default_nettype none
module adc_result_readout_port_test
  import adc_readout_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic coreBusy = 1'b0;
  logic csN = 1'b1;
  logic rdN = 1'b1;
  logic sclk, hostCsN, busy, serialOutA, serialOutAOe, serialOutB, serialOutBOe;
  logic firstChannelFlag, firstChannelFlagOe;
  logic [WORD_BITS-1:0] parallelDataOut, parallelDataOe;
  resultBank_type coreResults = '0;
  resultBank_type bank = '0;
  modePins_type modePins = '0;
  strobes_type strobes;
  logic [31:0] seed = 32'h0000_7a51;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  // 200 MHz clock; chip select is shared with the host model, both idle high
  always #2.5 clk = ~clk;
  assign strobes = strobes_type'{csN & hostCsN, rdN};
  adc_result_readout_port dut (.*);
  host_serial_model host (.sclk(sclk), .csN(hostCsN),
    .lineA(serialOutAOe ? serialOutA : 1'bz), .lineB(serialOutBOe ? serialOutB : 1'bz),
    .flag(firstChannelFlagOe ? firstChannelFlag : 1'bz));
  // fixed-seed shift register feeding the core results
  function automatic logic [15:0] rnd();
    seed = {seed[30:0], ^(seed & 32'h8020_0003)};
    return seed[15:0];
  endfunction : rnd
  // strobe k of sixteen: high-byte-first puts the upper byte on even strobes
  function automatic logic [15:0] byteOf(input int k, input logic h);
    return (k[0] == h) ? 16'(bank[k/2][7:0]) : 16'(bank[k/2][15:8]);
  endfunction : byteOf
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // one read strobe; tied mode drops chip select with it
  task automatic rd(input logic tied, input logic [15:0] e, input logic f,
                    input logic [15:0] oe);
    rdN = 1'b0;
    if (tied) csN = 1'b0;
    repeat (6) @(negedge clk);
    chk("data", e, parallelDataOut);
    chk("flag", {15'h0000, f}, {15'h0000, firstChannelFlag});
    chk("oe", oe, parallelDataOe);
    rdN = 1'b1;
    if (tied) csN = 1'b1;
    repeat (6) @(negedge clk);
  endtask : rd
  // one conversion, optionally with a tied read while busy is high
  task automatic conv(input logic readOld);
    for (int i = 0; i < CHANNELS; i++) coreResults[i] = rnd();
    coreResults[3] = 16'h8000;
    coreBusy = 1'b1;
    repeat (4) @(negedge clk);
    if (readOld) rd(1'b1, bank[0], 1'b1, OE_ALL);
    coreBusy = 1'b0;
    bank = coreResults;
    repeat (6) @(negedge clk);
  endtask : conv
  // line A in channel order, line B from channel 5; flag marks the first word
  task automatic scheck();
    for (int i = 0; i < CHANNELS; i++) begin
      chk("line a", bank[i], host.capA[i]);
      chk("line b", bank[i ^ 4], host.capB[i]);
      chk("serial flag", {15'h0000, i == 0}, {15'h0000, host.flagSeen[i]});
    end
  endtask : scheck
  // main sequence: parallel tied and separate, byte in both orders, serial
  initial begin
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    conv(1'b0);
    for (int i = 0; i < CHANNELS; i++) rd(1'b1, bank[i], i == 0, OE_ALL);
    conv(1'b1);
    csN = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 0; i < CHANNELS; i++) rd(1'b0, bank[i], i == 0, OE_ALL);
    csN = 1'b1;
    repeat (6) @(negedge clk);
    chk("flag oe", 16'h0000, {15'h0000, firstChannelFlagOe});
    $display("parallel test done");
    for (int h = 0; h < 2; h++) begin
      modePins = '{1'b1, 1'b1, h[0]};
      conv(1'b0);
      csN = 1'b0;
      for (int k = 0; k < 16; k++) rd(1'b0, byteOf(k, h[0]), k < 2, OE_LOW_BYTE);
      csN = 1'b1;
    end
    $display("byte test done");
    modePins = '{1'b1, 1'b0, 1'b0};
    conv(1'b0);
    host.frame(8, 0);
    scheck();
    for (int i = 0; i < CHANNELS; i++) host.frame(1, i);
    scheck();
    $display("serial test done");
    give_verdict();
  end
  // hang guard: the run needs about 9100 clocks
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      give_verdict();
    end
  end
endmodule : adc_result_readout_port_test
`default_nettype wire
